// [src/port_ab_pkg.sv]
// port_ab_pkg: shared types and constants for the port a/b override logic
// assumes a single clock domain, clk_sys at 200 MHz, no register bus
package port_ab_pkg;

  // ----------------------------------------------------------------
  // widths and pin positions
  // ----------------------------------------------------------------
  localparam int PORT_W      = 8;
  localparam int LCD_SEG_LO  = 4;   // first port a pin used as segment driver
  localparam int SPI_SS_BIT  = 0;
  localparam int SPI_SCK_BIT = 1;
  localparam int SPI_MOSI_BIT = 2;
  localparam int SPI_MISO_BIT = 3;
  localparam int TMR_LO_BIT  = 4;   // first port b pin with compare output

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] PORT_RST   = 8'h00;
  localparam logic [1:0] DUTY_RST   = 2'h0;

  // one pin's resolved pad controls
  typedef struct packed {
    logic pullOn;     // pull-up enabled
    logic driveOn;    // output driver enabled
    logic outVal;     // value put on the pad when driven
    logic inputOn;    // digital input not clamped
  } pad_ctrl_t;

  // one pin's override set
  typedef struct packed {
    logic pullOverrideEn;
    logic pullOverrideVal;
    logic dirOverrideEn;
    logic dirOverrideVal;
    logic valueOverrideEn;
    logic valueOverrideVal;
    logic toggleOverrideEn;
    logic inputEnOverrideEn;
    logic inputEnOverrideVal;
  } override_t;

  // port register bits for one port: direction and output latch
  typedef struct packed {
    logic [7:0] dirBits;
    logic [7:0] outLatch;
  } port_regs_t;

  // spi side of port b
  typedef struct packed {
    logic spiOn;
    logic spiMasterSelect;
    logic slaveOut;
    logic masterOut;
    logic clockOut;
  } spi_ctrl_t;

  // digital inputs handed to the spi
  typedef struct packed {
    logic masterIn;
    logic slaveIn;
    logic clockIn;
    logic slaveSelect;
  } spi_in_t;

endpackage

// [src/pad_resolve.sv]
// pad_resolve: applies one pin's override set to its port bits
// assumes overrides come from logic on the same clock; purely combinational
`timescale 1ns/1ps
module pad_resolve (
  input  wire port_ab_pkg::override_t ovr,
  input  wire logic                   dirBit,
  input  wire logic                   outLatchBit,
  input  wire logic                   globalPullupOff,
  input  wire logic                   sleepClamp,
  output      port_ab_pkg::pad_ctrl_t pad
);
  import port_ab_pkg::*;

  logic latchEff;

  // ----------------------------------------------------------------
  // generic override merge
  // ----------------------------------------------------------------
  // toggle flips the latch before it reaches pull-up and value paths
  always_comb begin
    latchEff = outLatchBit ^ ovr.toggleOverrideEn;
    pad.pullOn = ovr.pullOverrideEn ? ovr.pullOverrideVal
                 : (~dirBit & latchEff & ~globalPullupOff);
    pad.driveOn = ovr.dirOverrideEn ? ovr.dirOverrideVal : dirBit;
    // value override only counts while the driver is on
    pad.outVal = (pad.driveOn & ovr.valueOverrideEn) ? ovr.valueOverrideVal
                 : latchEff;
    pad.inputOn = ovr.inputEnOverrideEn ? ovr.inputEnOverrideVal
                  : ~sleepClamp;
  end

endmodule // pad_resolve

// [src/port_ab_alternate_override.sv]
// port_ab_alternate_override: alternate-function pad control for ports a and b
// assumes lcd, timer, spi and pin-change units and the sleep controller sit on
// clk_sys; pad inputs arrive from pins and are synchronised here for the port
//
// Behaviour
// - port a pins 4..7 carry lcd segments 0..3 on the analog path
// - port a pins 0..3 carry lcd commons 0..3 on the analog path
// - segment pins: lcd_on forces pull-up off, driver off, input off
// - common pins 1..3 also need duty select above 0, 1, 2
// - port b: compare outputs on 7..4, spi on 3..0, pin-change 15..8
// - compare output replaces port value while its enable is set
// - compare output reaches pin only when software sets direction
// - pin-change mask and group enable force digital input on
// - miso input as master; as slave latch-dir with slave output value
// - mosi input as slave; as master carries master output
// - sck input as slave; as master carries clock output
// - ss input as slave, slave active while ss low; master untouched
// - forced-input spi pins keep pull-up from their output latch
// - raw digital input of spi pins feeds pin-change and spi
// - compare pins also carry the timer pwm output
// - without override, pull-up needs dir 0, latch 1, pull-up-off 0
// - value override acts only while the driver is enabled
// - without input override, input follows the sleep clamp
`timescale 1ns/1ps
module port_ab_alternate_override (
  input  wire logic                    clk_sys,
  input  wire logic                    srst,
  // port registers
  input  wire port_ab_pkg::port_regs_t portA,
  input  wire port_ab_pkg::port_regs_t portB,
  input  wire logic                    globalPullupOff,
  input  wire logic                    sleepClamp,
  // lcd controller
  input  wire logic                    lcdOn,
  input  wire logic [1:0]              lcdDutySelect,
  input  wire logic [3:0]              segmentDrive,
  input  wire logic [3:0]              commonDrive,
  // timers, index 0..3 = pins 4..7
  input  wire logic [3:0]              cmpOutEn,
  input  wire logic [3:0]              cmpOut,
  // pin-change
  input  wire logic [7:0]              pinChangeMask,
  input  wire logic                    pinChangeGroupOn,
  // spi
  input  wire port_ab_pkg::spi_ctrl_t  spiCtrl,
  // pads
  input  wire logic [7:0]              padInA,
  input  wire logic [7:0]              padInB,
  output      port_ab_pkg::pad_ctrl_t [7:0] padA,
  output      port_ab_pkg::pad_ctrl_t [7:0] padB,
  output      logic [7:0]              analogPadPathOe,
  output      logic [7:0]              analogPadPathDrive,
  // digital inputs towards peripherals
  output      logic [7:0]              pinChangeIn,
  output      port_ab_pkg::spi_in_t    spiIn,
  output      logic                    spiSlaveActive,
  output      logic [7:0]              pinReadA,
  output      logic [7:0]              pinReadB
);
  import port_ab_pkg::*;

  override_t  ovrA [PORT_W];
  override_t  ovrB [PORT_W];
  logic [7:0] rawA;
  logic [7:0] rawB;
  logic [7:0] syncA1_reg;
  logic [7:0] syncA1_next;
  logic [7:0] syncA2_reg;
  logic [7:0] syncA2_next;
  logic [7:0] syncB1_reg;
  logic [7:0] syncB1_next;
  logic [7:0] syncB2_reg;
  logic [7:0] syncB2_next;
  logic [3:0] comActive;
  logic       spiMaster;
  logic       spiSlave;

  // ----------------------------------------------------------------
  // lcd qualification
  // ----------------------------------------------------------------
  // common 0 always used; higher commons only as duty grows
  always_comb begin
    comActive[0] = lcdOn;
    comActive[1] = lcdOn & (lcdDutySelect > 2'h0);
    comActive[2] = lcdOn & (lcdDutySelect > 2'h1);
    comActive[3] = lcdOn & (lcdDutySelect > 2'h2);
  end

  // ----------------------------------------------------------------
  // port a override sets
  // ----------------------------------------------------------------
  // lcd takes pads fully: no pull-up, no driver, input clamped
  genvar gi;
  generate
    for (gi = 0; gi < PORT_W; gi++) begin : g_ovr_a
      logic lcdTake;
      assign lcdTake = (gi >= LCD_SEG_LO) ? lcdOn : comActive[gi % 4];
      always_comb begin
        ovrA[gi] = '0;
        ovrA[gi].pullOverrideEn    = lcdTake;
        ovrA[gi].dirOverrideEn     = lcdTake;
        ovrA[gi].inputEnOverrideEn = lcdTake;
      end
      pad_resolve u_pad_a (
        .ovr             (ovrA[gi]),
        .dirBit          (portA.dirBits[gi]),
        .outLatchBit     (portA.outLatch[gi]),
        .globalPullupOff (globalPullupOff),
        .sleepClamp      (sleepClamp),
        .pad             (padA[gi])
      );
    end
  endgenerate

  // analog path: segments on 7..4, commons on 3..0
  always_comb begin
    analogPadPathDrive = {segmentDrive, commonDrive};
    analogPadPathOe    = {{4{lcdOn}}, comActive};
  end

  // ----------------------------------------------------------------
  // port b override sets
  // ----------------------------------------------------------------
  // spi mode decode; master/slave sense per pin as the pin text reads
  always_comb begin
    spiMaster = spiCtrl.spiOn & spiCtrl.spiMasterSelect;
    spiSlave  = spiCtrl.spiOn & ~spiCtrl.spiMasterSelect;
  end

  generate
    for (gi = 0; gi < PORT_W; gi++) begin : g_ovr_b
      logic pcKeep;
      // pin-change keeps the input alive even in deep sleep
      assign pcKeep = pinChangeMask[gi] & pinChangeGroupOn;
      // split per pin group so no compare index is ever formed below pin 4
      if (gi >= TMR_LO_BIT) begin : g_cmp
        // direction left to software so the compare pin needs dir set
        always_comb begin
          ovrB[gi]                    = '0;
          ovrB[gi].valueOverrideEn    = cmpOutEn[gi - TMR_LO_BIT];
          ovrB[gi].valueOverrideVal   = cmpOut[gi - TMR_LO_BIT];
          ovrB[gi].inputEnOverrideEn  = pcKeep;
          ovrB[gi].inputEnOverrideVal = 1'b1;
        end
      end else begin : g_spi
        // pull-up still follows the latch when spi forces input
        always_comb begin
          ovrB[gi]                    = '0;
          ovrB[gi].inputEnOverrideEn  = pcKeep;
          ovrB[gi].inputEnOverrideVal = 1'b1;
          ovrB[gi].pullOverrideVal    = portB.outLatch[gi] & ~globalPullupOff;
          case (gi)
            SPI_MISO_BIT: begin
              ovrB[gi].pullOverrideEn   = spiMaster;
              ovrB[gi].dirOverrideEn    = spiMaster;
              ovrB[gi].valueOverrideEn  = spiSlave;
              ovrB[gi].valueOverrideVal = spiCtrl.slaveOut;
            end
            SPI_MOSI_BIT: begin
              ovrB[gi].pullOverrideEn   = spiSlave;
              ovrB[gi].dirOverrideEn    = spiSlave;
              ovrB[gi].valueOverrideEn  = spiMaster;
              ovrB[gi].valueOverrideVal = spiCtrl.masterOut;
            end
            SPI_SCK_BIT: begin
              ovrB[gi].pullOverrideEn   = spiSlave;
              ovrB[gi].dirOverrideEn    = spiSlave;
              ovrB[gi].valueOverrideEn  = spiMaster;
              ovrB[gi].valueOverrideVal = spiCtrl.clockOut;
            end
            default: begin
              ovrB[gi].pullOverrideEn   = spiSlave;
              ovrB[gi].dirOverrideEn    = spiSlave;
            end
          endcase
        end
      end
      pad_resolve u_pad_b (
        .ovr             (ovrB[gi]),
        .dirBit          (portB.dirBits[gi]),
        .outLatchBit     (portB.outLatch[gi]),
        .globalPullupOff (globalPullupOff),
        .sleepClamp      (sleepClamp),
        .pad             (padB[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // digital input path
  // ----------------------------------------------------------------
  // clamp gates the raw pad before any synchroniser, as the pad does
  always_comb begin
    for (int i = 0; i < PORT_W; i++) begin
      rawA[i] = padInA[i] & padA[i].inputOn;
      rawB[i] = padInB[i] & padB[i].inputOn;
    end
  end

  // peripherals take the unsynchronised input; slave-active alone uses ss from the second sync stage
  always_comb begin
    pinChangeIn       = rawB;
    spiIn.masterIn    = rawB[SPI_MISO_BIT];
    spiIn.slaveIn     = rawB[SPI_MOSI_BIT];
    spiIn.clockIn     = rawB[SPI_SCK_BIT];
    spiIn.slaveSelect = rawB[SPI_SS_BIT];
    spiSlaveActive    = spiSlave & ~syncB2_reg[SPI_SS_BIT];
  end

  // ----------------------------------------------------------------
  // port read synchronisers
  // ----------------------------------------------------------------
  // two stages so pin reads never see a metastable level
  always_comb begin
    syncA1_next = srst ? PORT_RST : rawA;
    syncA2_next = srst ? PORT_RST : syncA1_reg;
    syncB1_next = srst ? PORT_RST : rawB;
    syncB2_next = srst ? PORT_RST : syncB1_reg;
  end

  always_ff @(posedge clk_sys) begin
    syncA1_reg <= syncA1_next;
    syncA2_reg <= syncA2_next;
    syncB1_reg <= syncB1_next;
    syncB2_reg <= syncB2_next;
  end

  assign pinReadA = syncA2_reg;
  assign pinReadB = syncB2_reg;

endmodule // port_ab_alternate_override

// [test/port_ab_sva.sv]
// port_ab_sva: concurrent checks on the pad override block ports
// assumes it is bound into port_ab_alternate_override, one clk_sys domain
`timescale 1ns/1ps
module port_ab_sva (
  input logic                         clk_sys,
  input logic                         srst,
  input port_ab_pkg::port_regs_t      portA,
  input port_ab_pkg::port_regs_t      portB,
  input logic                         globalPullupOff,
  input logic                         lcdOn,
  input logic [1:0]                   lcdDutySelect,
  input logic [3:0]                   cmpOutEn,
  input logic [3:0]                   cmpOut,
  input logic [7:0]                   pinChangeMask,
  input logic                         pinChangeGroupOn,
  input port_ab_pkg::spi_ctrl_t       spiCtrl,
  input logic [7:0]                   padInB,
  input port_ab_pkg::pad_ctrl_t [7:0] padA,
  input port_ab_pkg::pad_ctrl_t [7:0] padB,
  input logic [7:0]                   pinChangeIn,
  input port_ab_pkg::spi_in_t         spiIn,
  input logic [7:0]                   pinReadB
);
  import port_ab_pkg::*;
  logic [7:0] puA, drA, vA, inA, puB, drB, vB, inB, gB;
  // ----------------------------------------------------------------
  // per-pin slices of the pad controls
  // ----------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      {puA[i], drA[i], vA[i], inA[i]} = padA[i];
      {puB[i], drB[i], vB[i], inB[i]} = padB[i];
    end
  end
  assign gB = padInB & inB;  // clamped view, as the peripherals see it
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  seg_pads_off_a: assert property (lcdOn |-> (puA[7:4] | drA[7:4] | inA[7:4]) == 4'h0)
    else $error("segment pad not released");
  com_duty_a: assert property (lcdOn && lcdDutySelect == 2'h1 |->
    drA[3:0] == {portA.dirBits[3:2], 2'b00}) else $error("common pads wrong for duty 1");
  cmp_value_a: assert property (((vB[7:4] ^ ((cmpOutEn & cmpOut) |
    (~cmpOutEn & portB.outLatch[7:4]))) & drB[7:4]) == 4'h0) else $error("compare value");
  cmp_dir_a: assert property (drB[7:4] == portB.dirBits[7:4] && puB[7:4] ==
    (~portB.dirBits[7:4] & portB.outLatch[7:4] & {4{!globalPullupOff}}))
    else $error("compare pin direction or pull-up");
  pc_input_a: assert property (pinChangeGroupOn |-> (inB & pinChangeMask) == pinChangeMask)
    else $error("pin-change input not forced on");
  master_pins_a: assert property (spiCtrl.spiOn && spiCtrl.spiMasterSelect |->
    !drB[3] && puB[3] == (portB.outLatch[3] && !globalPullupOff)
    && drB[2:0] == portB.dirBits[2:0]) else $error("master pin setup");
  slave_pins_a: assert property (spiCtrl.spiOn && !spiCtrl.spiMasterSelect |->
    drB[3:0] == {portB.dirBits[3], 3'h0} && (!drB[3] || vB[3] == spiCtrl.slaveOut))
    else $error("slave pin setup");
  read_sync_a: assert property (!$past(srst) && !$past(srst, 2) |->
    pinReadB == $past(gB, 2)) else $error("pin read not two cycles behind");
  raw_feed_a: assert property (pinChangeIn == gB && spiIn == gB[3:0])
    else $error("raw input feed");
  lcd_full_c: cover property (lcdOn && lcdDutySelect == 2'h3);
  spi_master_c: cover property (spiCtrl.spiOn && spiCtrl.spiMasterSelect);
  spi_slave_c: cover property (spiCtrl.spiOn && !spiCtrl.spiMasterSelect && drB[3]);
endmodule // port_ab_sva

// [test/port_ab_peer.sv]
// port_ab_peer: behavioural timers and spi facing the override block
// assumes clk_sys from the bench; it moves 1 ns after each rising edge
`timescale 1ns/1ps
module port_ab_peer (
  input  logic                   clk_sys,
  input  logic                   srst,
  input  logic                   spiOnReq,
  input  logic                   masterReq,
  input  logic [3:0]             cmpEnReq,
  output port_ab_pkg::spi_ctrl_t spiCtrl,
  output logic [3:0]             cmpOutEn,
  output logic [3:0]             cmpOut,
  output logic [3:0]             segmentDrive,
  output logic [3:0]             commonDrive
);
  import port_ab_pkg::*;
  logic [7:0] count_reg;
  initial {count_reg, spiCtrl, cmpOutEn, cmpOut, segmentDrive, commonDrive} = '0;
  // free counter stands in for timer and shift state, so values change often
  always @(posedge clk_sys) begin
    #1;
    count_reg = srst ? 8'h00 : count_reg + 8'h01;
    cmpOutEn = cmpEnReq;  // index 0..3 = timer0 a, timer1 a, timer1 b, timer2 a
    cmpOut = {count_reg[7], count_reg[6], count_reg[5] ^ count_reg[0], count_reg[4]};
    spiCtrl = '{spiOnReq, masterReq, count_reg[0], count_reg[1], count_reg[2]};
    segmentDrive = count_reg[3:0];
    commonDrive = ~count_reg[3:0];
  end
endmodule // port_ab_peer

// [test/test_port_ab_alternate_override.sv]
// test_port_ab_alternate_override: random self-checking bench of the pad override block
// assumes the package, design, peer model and checker are compiled before it
`timescale 1ns/1ps
module test_port_ab_alternate_override;
  import port_ab_pkg::*;
  logic            clk_sys, srst, gpo, clamp, lcdOn, pcOn, spiOnReq, mstReq, sAct;
  logic [1:0]      duty;
  logic [3:0]      cmpEnReq, cmpOutEn, cmpOut, segD, comD;
  logic [7:0]      pcMask, padInA, padInB, aOe, aDrv, rdA, rdB, h0, h1, hA0, hA1;
  port_regs_t      portA, portB;
  spi_ctrl_t       spiCtrl;
  pad_ctrl_t [7:0] padA, padB;
  logic [97:0]     expQ[$];
  logic [97:0]     e;
  int              num_errors, num_checks, seed, vld;
  port_ab_peer i_port_ab_peer (.clk_sys(clk_sys), .srst(srst), .spiOnReq(spiOnReq),
    .masterReq(mstReq), .cmpEnReq(cmpEnReq), .spiCtrl(spiCtrl), .cmpOutEn(cmpOutEn),
    .cmpOut(cmpOut), .segmentDrive(segD), .commonDrive(comD));
  port_ab_alternate_override i_port_ab_alternate_override (.clk_sys(clk_sys), .srst(srst),
    .portA(portA), .portB(portB), .globalPullupOff(gpo), .sleepClamp(clamp), .lcdOn(lcdOn),
    .lcdDutySelect(duty), .segmentDrive(segD), .commonDrive(comD), .cmpOutEn(cmpOutEn),
    .cmpOut(cmpOut), .pinChangeMask(pcMask), .pinChangeGroupOn(pcOn), .spiCtrl(spiCtrl),
    .padInA(padInA), .padInB(padInB), .padA(padA), .padB(padB), .analogPadPathOe(aOe),
    .analogPadPathDrive(aDrv), .pinChangeIn(), .spiIn(), .spiSlaveActive(sAct),
    .pinReadA(rdA), .pinReadB(rdB));
  // ----------------------------------------------------------------
  // reference: o = {pull en, pull val, dir en, dir val, value en, value, input en, input}
  // ----------------------------------------------------------------
  function automatic logic [3:0] rs(input logic [7:0] o, input logic d, l);
    logic dr;
    dr = o[5] ? o[4] : d;
    return {o[7] ? o[6] : !d && l && !gpo, dr, o[3] && dr ? o[2] : l, o[1] ? o[0] : !clamp};
  endfunction
  // one random vector in mode m; its expected outputs go on the queue
  task automatic step(input logic [4:0] m);
    logic [7:0][3:0] eA, eB;
    logic [7:0]      eo, g, gA, ed;
    logic [31:0]     r;
    logic            en, fr, pv;
    @(posedge clk_sys);
    #0.5;
    r = $random(seed);
    {spiOnReq, mstReq, lcdOn, duty} = m;
    {portA, portB} = $random(seed);
    {cmpEnReq, pcMask, padInA, padInB, gpo, clamp, pcOn} = r[30:0];
    #1;  // let the peer settle first
    for (int i = 0; i < 8; i++) begin
      en = lcdOn && (i > 3 || i == 0 || duty > i - 1);
      fr = spiCtrl.spiOn && ((i == 3) == spiCtrl.spiMasterSelect);
      pv = spiCtrl.spiOn && i > 0 && ((i == 3) != spiCtrl.spiMasterSelect);
      eo[i] = en;
      eA[i] = rs({en, 1'b0, en, 3'h0, en, 1'b0}, portA.dirBits[i], portA.outLatch[i]);
      eB[i] = i > 3 ? rs({4'h0, cmpOutEn[i-4], cmpOut[i-4], pcMask[i] && pcOn, 1'b1},
          portB.dirBits[i], portB.outLatch[i])
        : rs({fr, portB.outLatch[i] && !gpo, fr, 1'b0, pv, spiCtrl[i-1], pcMask[i] && pcOn,
          1'b1}, portB.dirBits[i], portB.outLatch[i]);
      g[i] = padInB[i] && eB[i][0];
      gA[i] = padInA[i] && eA[i][0];
      ed[i] = i > 3 ? segD[i-4] : comD[i];
    end
    // slave is active while the synchronised select, two steps old, is low
    expQ.push_back({eA, eB, eo, ed,
      spiCtrl.spiOn && !spiCtrl.spiMasterSelect && !h1[0], h1, hA1, vld > 1});
    {h1, h0} = {h0, g};
    {hA1, hA0} = {hA0, gA};
    vld++;
  endtask
  // takes the oldest note whenever the settled outputs are looked at
  always @(negedge clk_sys) begin
    if (expQ.size() > 0) begin
      e = expQ.pop_front();
      num_checks++;
      if ({padA, padB, aOe, aDrv, sAct} !== e[97:17] ||
          (e[0] && {rdB, rdA} !== e[16:1])) begin
        num_errors++;
        $display("CHECK FAILED at %0t: outputs %h expected %h", $time,
          {padA, padB, aOe, aDrv, sAct, rdB, rdA}, e[97:1]);
      end
    end
  end
  task automatic end_of_test();
    $display("checks %0d, errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  // the run needs about 270 cycles; this limit is far beyond it
  initial begin
    #20000;
    num_errors++;
    end_of_test();
  end
  // every spi, lcd and duty mode, eight random vectors each
  initial begin
    seed = 44;
    {portA, portB, pcMask, padInA, padInB, gpo, clamp, lcdOn, pcOn} = '0;
    {spiOnReq, mstReq, duty, cmpEnReq} = '0;
    {h0, h1, hA0, hA1} = '0;  // both sync stages hold zero straight out of reset
    srst = 1'b1;
    repeat (8) @(posedge clk_sys);
    #0.5;
    srst = 1'b0;
    for (int k = 0; k < 32; k++) begin
      repeat (8) step(k[4:0]);
      $display("test %0d done, mode %b", k, k[4:0]);
    end
    repeat (2) @(posedge clk_sys);
    end_of_test();
  end
endmodule // test_port_ab_alternate_override
bind port_ab_alternate_override port_ab_sva i_port_ab_sva (.*);
